// ---- adop_consts.vh ----
// constants shared by the alarm driven output pulser
`ifndef ADOP_CONSTS_VH
`define ADOP_CONSTS_VH
// register byte offsets, line registers repeat every stride
`define ADOP_OFF_CTRL    8'h00
`define ADOP_OFF_DELAY   8'h04
`define ADOP_OFF_HOLD    8'h08
`define ADOP_OFF_WIDTH   8'h0C
`define ADOP_LINE_STRIDE 8'h10
`define ADOP_OFF_DICFG   8'h20
`define ADOP_OFF_THR     8'h24
`define ADOP_OFF_STATUS  8'h28
`define ADOP_OFF_CMD     8'h2C
`define ADOP_OFF_COUNT   8'h30
// control register fields
`define ADOP_CTRL_EN     0
`define ADOP_CTRL_ON     2:1
`define ADOP_CTRL_OFF    4:3
`define ADOP_CTRL_SRC    5
`define ADOP_CTRL_RST    6'h02
// action codes
`define ADOP_ACT_LOW     2'h0
`define ADOP_ACT_HIGH    2'h1
`define ADOP_ACT_PULSE   2'h2
// initial level codes
`define ADOP_INIT_LOW    2'h0
`define ADOP_INIT_HIGH   2'h1
`define ADOP_INIT_LAST   2'h2
// reset values and field widths
`define ADOP_WIDTH_RST   15'h000A
`define ADOP_HI_LSB      16
// timing
`define ADOP_CLK_NS      10
`define ADOP_MS_NS       1000000
`define ADOP_MS_CYC      (`ADOP_MS_NS / `ADOP_CLK_NS)
`define ADOP_S_MS        1000
// bus responses
`define ADOP_RESP_OKAY   2'h0
`define ADOP_RESP_SLVERR 2'h2
`endif

// ---- adop_tick.v ----
// enable pulse divider for the millisecond and second time bases
`timescale 1ns/10ps
`default_nettype none
module adop_tick #(
  parameter DIV = 1000
) (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // count enable and output pulse
  input  wire en,
  output reg  tick
);
  reg [31:0] cnt_q;

  // count enables, pulse once per DIV of them
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 32'h0000_0000;
      tick  <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (en)
      begin
        if (cnt_q == DIV - 1)
        begin
          cnt_q <= 32'h0000_0000;
          tick  <= 1'b1;
        end
        else
          cnt_q <= cnt_q + 32'h0000_0001;
      end
    end
  end
endmodule // adop_tick
`default_nettype wire

// ---- adop_line.v ----
// one alarm driven output line with delay, hold and square wave
`timescale 1ns/10ps
`default_nettype none
`include "adop_consts.vh"
module adop_line (
  // clock, reset and time bases
  input  wire        clk,
  input  wire        rst,
  input  wire        ms_tick,
  input  wire        s_tick,
  // configuration
  input  wire        en,
  input  wire        alarm,
  input  wire [1:0]  on_act,
  input  wire [1:0]  off_act,
  input  wire [14:0] delay,
  input  wire [7:0]  hold,
  input  wire [14:0] lo_w,
  input  wire [14:0] hi_w,
  // power on load and manual toggle
  input  wire        init_ld,
  input  wire        init_lvl,
  input  wire        toggle,
  // line state
  output reg         lvl_q,
  output wire        busy
);
  localparam IDLE = 2'b00;
  localparam WAIT = 2'b01;
  localparam RUN  = 2'b10;

  reg  [1:0]  st_q;
  reg  [1:0]  act_q;
  reg         alm_q;
  reg         ph_q;
  reg  [14:0] cnt_q;
  reg  [7:0]  sec_q;
  wire        evt   = en && (alarm != alm_q);
  wire [1:0]  nact  = alarm ? on_act : off_act;
  wire [14:0] w_raw = ph_q ? hi_w : lo_w;
  wire [14:0] w_eff = (w_raw == 15'h0000) ? 15'h0001 : w_raw;

  assign busy = (st_q != IDLE);

  // action sequencer: delay, run, hold expiry, pulse phases
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q  <= IDLE;
      act_q <= `ADOP_ACT_LOW;
      alm_q <= 1'b0;
      ph_q  <= 1'b0;
      cnt_q <= 15'h0000;
      sec_q <= 8'h00;
      lvl_q <= 1'b0;
    end
    else
    begin
      alm_q <= alarm;
      if (init_ld)
        lvl_q <= init_lvl;
      else if (evt)
      begin
        act_q <= nact;
        cnt_q <= 15'h0000;
        sec_q <= 8'h00;
        ph_q  <= 1'b1;
        if (delay == 15'h0000)
        begin
          st_q  <= RUN;
          lvl_q <= (nact != `ADOP_ACT_LOW);
        end
        else
          st_q <= WAIT;
      end
      else
      begin
        case (st_q)
          WAIT:
          begin
            if (ms_tick)
            begin
              if (cnt_q + 15'h0001 >= delay)
              begin
                st_q  <= RUN;
                cnt_q <= 15'h0000;
                lvl_q <= (act_q != `ADOP_ACT_LOW);
              end
              else
                cnt_q <= cnt_q + 15'h0001;
            end
          end
          RUN:
          begin
            if (s_tick)
              sec_q <= sec_q + 8'h01;
            if (s_tick && hold != 8'h00 && sec_q + 8'h01 == hold)
              st_q <= IDLE;
            else if (act_q == `ADOP_ACT_PULSE && ms_tick)
            begin
              if (cnt_q + 15'h0001 >= w_eff)
              begin
                cnt_q <= 15'h0000;
                ph_q  <= ~ph_q;
                lvl_q <= ~ph_q;
              end
              else
                cnt_q <= cnt_q + 15'h0001;
            end
          end
          default:
            st_q <= IDLE;
        endcase
      end
      if (toggle && !init_ld)
        lvl_q <= ~lvl_q;
    end
  end
endmodule // adop_line
`default_nettype wire

// ---- adop_top.v ----
// alarm driven output pulser with two lines behind an axi4-lite slave
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "adop_consts.vh"
// Overview of operation
// - enabled line performs its configured high, low or pulse action on alarm assertion
// - enabled line performs its own independently chosen action on alarm removal
// - square wave alternates low and high, each held its own width
// - low phase width programmable 1 to 30000 ms, default 10 ms
// - high phase width programmable 1 to 30000 ms, default 10 ms
// - at power on each line takes high, low or last power-off level
// - first output starts after programmable 0 to 30000 ms delay, zero immediate
// - action stops after hold of 0 to 255 s, zero runs until next
// - each line follows first or second input alarm, first by default
// - each line has its own enable, default off, disabled ignores alarms
// - levels and alarm status readable, per-input command clears counter alarm
// - input alarm active on high or open, inactive low, inversion swaps
module adop_top #(
  parameter MS_DIV = `ADOP_MS_CYC
) (
  // clock and reset
  input  wire        CLK,
  input  wire        RST,
  // axi4-lite write address and data
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  // axi4-lite write response
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  // axi4-lite read
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  // input lines and power-on straps
  input  wire [1:0]  IN_LINE,
  input  wire [3:0]  INIT_SEL,
  input  wire [1:0]  LAST_LVL,
  // output lines
  output wire [1:0]  OUT_LINE
);
  // configuration state
  reg  [5:0]  ctrl_q [0:1];
  reg  [14:0] dly_q  [0:1];
  reg  [7:0]  hold_q [0:1];
  reg  [14:0] low_q  [0:1];
  reg  [14:0] high_q [0:1];
  reg  [3:0]  dicfg_q;
  reg  [31:0] thr_q;
  // input side state
  reg  [7:0]  sy1_q;
  reg  [7:0]  sy2_q;
  reg  [1:0]  prev_q;
  reg  [15:0] cnt_q [0:1];
  reg  [1:0]  calm_q;
  reg  [1:0]  clr_q;
  reg  [1:0]  tog_q;
  reg  [1:0]  boot_q;
  reg         init_ld_q;
  // bus state
  reg  [7:0]  awa_q;
  reg  [31:0] wd_q;
  reg  [3:0]  ws_q;
  reg         awh_q;
  reg         wh_q;
  reg  [31:0] rd_d;
  reg         rok_d;
  wire        ms_tick;
  wire        s_tick;
  wire [1:0]  busy;
  wire [1:0]  in_s   = sy2_q[1:0];
  wire [1:0]  al_lvl = in_s ^ dicfg_q[1:0];
  wire [1:0]  alarm;
  wire        wl     = awa_q[4];
  wire        rl     = S_AXI_ARADDR[4];
  wire        wline  = awa_q < `ADOP_OFF_DICFG;
  wire        rline  = S_AXI_ARADDR < `ADOP_OFF_DICFG;
  wire [31:0] msk    = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}}; // byte lane mask
  wire        wok_d  = wline || awa_q == `ADOP_OFF_DICFG || awa_q == `ADOP_OFF_THR || awa_q == `ADOP_OFF_CMD;
  integer     i;
  integer     j;

  // time bases: millisecond from clock, second from milliseconds
  adop_tick #(.DIV(MS_DIV)) u_ms (
    .clk  (CLK),
    .rst  (RST),
    .en   (1'b1),
    .tick (ms_tick)
  );
  adop_tick #(.DIV(`ADOP_S_MS)) u_s (
    .clk  (CLK),
    .rst  (RST),
    .en   (ms_tick),
    .tick (s_tick)
  );

  // input alarm is live level or sticky counter alarm
  assign alarm[0] = dicfg_q[2] ? calm_q[0] : al_lvl[0];
  assign alarm[1] = dicfg_q[3] ? calm_q[1] : al_lvl[1];

  // two output lines
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_line
      wire [1:0] isel = sy2_q[2 + g*2 +: 2];
      reg        ilvl;
      // initial level from synchronised strap selection
      always @*
      begin
        case (isel)
          `ADOP_INIT_HIGH: ilvl = 1'b1;
          `ADOP_INIT_LAST: ilvl = sy2_q[6 + g];
          default:         ilvl = 1'b0;
        endcase
      end
      adop_line u_line (
        .clk      (CLK),
        .rst      (RST),
        .ms_tick  (ms_tick),
        .s_tick   (s_tick),
        .en       (ctrl_q[g][`ADOP_CTRL_EN]),
        .alarm    (alarm[ctrl_q[g][`ADOP_CTRL_SRC]]),
        .on_act   (ctrl_q[g][`ADOP_CTRL_ON]),
        .off_act  (ctrl_q[g][`ADOP_CTRL_OFF]),
        .delay    (dly_q[g]),
        .hold     (hold_q[g]),
        .lo_w     (low_q[g]),
        .hi_w     (high_q[g]),
        .init_ld  (init_ld_q),
        .init_lvl (ilvl),
        .toggle   (tog_q[g]),
        .lvl_q    (OUT_LINE[g]),
        .busy     (busy[g])
      );
    end
  endgenerate

  // pin synchronisers, power-on load after straps settle
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      sy1_q     <= 8'h00;
      sy2_q     <= 8'h00;
      boot_q    <= 2'h0;
      init_ld_q <= 1'b0;
    end
    else
    begin
      sy1_q     <= {LAST_LVL, INIT_SEL, IN_LINE};
      sy2_q     <= sy1_q;
      init_ld_q <= (boot_q == 2'h2);
      if (boot_q != 2'h3)
        boot_q <= boot_q + 2'h1;
    end
  end

  // event counters and sticky counter alarms, set beats clear
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      prev_q   <= 2'h0;
      calm_q   <= 2'h0;
      cnt_q[0] <= 16'h0000;
      cnt_q[1] <= 16'h0000;
    end
    else
    begin
      prev_q <= al_lvl;
      for (i = 0; i < 2; i = i + 1)
      begin
        if (dicfg_q[2 + i] && al_lvl[i] && !prev_q[i])
        begin
          cnt_q[i] <= clr_q[i] ? 16'h0001 : cnt_q[i] + 16'h0001;
          if (thr_q[i*16 +: 16] != 16'h0000 && cnt_q[i] + 16'h0001 == thr_q[i*16 +: 16])
            calm_q[i] <= 1'b1;
          else if (clr_q[i])
            calm_q[i] <= 1'b0;
        end
        else if (clr_q[i])
        begin
          cnt_q[i]  <= 16'h0000;
          calm_q[i] <= 1'b0;
        end
      end
    end
  end

  // write channels, register updates and command pulses
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `ADOP_RESP_OKAY;
      awa_q         <= 8'h00;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      awh_q         <= 1'b0;
      wh_q          <= 1'b0;
      clr_q         <= 2'h0;
      tog_q         <= 2'h0;
      dicfg_q       <= 4'h0;
      thr_q         <= 32'h0000_0000;
      for (j = 0; j < 2; j = j + 1)
      begin
        ctrl_q[j] <= `ADOP_CTRL_RST;
        dly_q[j]  <= 15'h0000;
        hold_q[j] <= 8'h00;
        low_q[j]  <= `ADOP_WIDTH_RST;
        high_q[j] <= `ADOP_WIDTH_RST;
      end
    end
    else
    begin
      clr_q <= 2'h0;
      tog_q <= 2'h0;
      S_AXI_AWREADY <= !awh_q && !S_AXI_BVALID && !(S_AXI_AWREADY && S_AXI_AWVALID);
      S_AXI_WREADY  <= !wh_q && !S_AXI_BVALID && !(S_AXI_WREADY && S_AXI_WVALID);
      if (S_AXI_AWREADY && S_AXI_AWVALID)
      begin
        awa_q <= S_AXI_AWADDR;
        awh_q <= 1'b1;
      end
      if (S_AXI_WREADY && S_AXI_WVALID)
      begin
        wd_q <= S_AXI_WDATA;
        ws_q <= S_AXI_WSTRB;
        wh_q <= 1'b1;
      end
      if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
      if (awh_q && wh_q && !S_AXI_BVALID)
      begin
        awh_q        <= 1'b0;
        wh_q         <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wok_d ? `ADOP_RESP_OKAY : `ADOP_RESP_SLVERR;
        if (wline)
        begin
          case ({4'h0, awa_q[3:0]})
            `ADOP_OFF_CTRL:  ctrl_q[wl] <= (ctrl_q[wl] & ~msk[5:0]) | (wd_q[5:0] & msk[5:0]);
            `ADOP_OFF_DELAY: dly_q[wl]  <= (dly_q[wl] & ~msk[14:0]) | (wd_q[14:0] & msk[14:0]);
            `ADOP_OFF_HOLD:  hold_q[wl] <= (hold_q[wl] & ~msk[7:0]) | (wd_q[7:0] & msk[7:0]);
            default:
            begin
              low_q[wl]  <= (low_q[wl] & ~msk[14:0]) | (wd_q[14:0] & msk[14:0]);
              high_q[wl] <= (high_q[wl] & ~msk[30:16]) | (wd_q[30:16] & msk[30:16]);
            end
          endcase
        end
        else
        begin
          case (awa_q)
            `ADOP_OFF_DICFG: dicfg_q <= (dicfg_q & ~msk[3:0]) | (wd_q[3:0] & msk[3:0]);
            `ADOP_OFF_THR:   thr_q   <= (thr_q & ~msk) | (wd_q & msk);
            `ADOP_OFF_CMD:
            begin
              clr_q <= ws_q[0] ? wd_q[1:0] : 2'h0;
              tog_q <= ws_q[0] ? wd_q[3:2] : 2'h0;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // read mux
  always @*
  begin
    rd_d  = 32'h0000_0000;
    rok_d = 1'b1;
    if (rline)
    begin
      case ({4'h0, S_AXI_ARADDR[3:0]})
        `ADOP_OFF_CTRL:  rd_d = {26'h000_0000, ctrl_q[rl]};
        `ADOP_OFF_DELAY: rd_d = {17'h0_0000, dly_q[rl]};
        `ADOP_OFF_HOLD:  rd_d = {24'h00_0000, hold_q[rl]};
        default:         rd_d = {1'b0, high_q[rl], 1'b0, low_q[rl]};
      endcase
    end
    else
    begin
      case (S_AXI_ARADDR)
        `ADOP_OFF_DICFG:  rd_d = {28'h000_0000, dicfg_q};
        `ADOP_OFF_THR:    rd_d = thr_q;
        `ADOP_OFF_STATUS: rd_d = {24'h00_0000, busy, alarm, in_s, OUT_LINE};
        `ADOP_OFF_CMD:    rd_d = 32'h0000_0000;
        `ADOP_OFF_COUNT:  rd_d = {cnt_q[1], cnt_q[0]};
        default:          rok_d = 1'b0;
      endcase
    end
  end

  // read channel, one read at a time
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `ADOP_RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARREADY && S_AXI_ARVALID);
      if (S_AXI_ARREADY && S_AXI_ARVALID)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_d;
        S_AXI_RRESP  <= rok_d ? `ADOP_RESP_OKAY : `ADOP_RESP_SLVERR;
      end
      else if (S_AXI_RVALID && S_AXI_RREADY)
      begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end
endmodule // adop_top
`default_nettype wire

// ---- adop_properties.sv ----
// port assertions for the alarm driven output pulser
`timescale 1ns/10ps
`default_nettype none
`include "adop_consts.vh"
module adop_chk (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST,
  // bus handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  // straps and lines
  input wire logic [3:0]  INIT_SEL,
  input wire logic [1:0]  LAST_LVL,
  input wire logic [1:0]  OUT_LINE
);
  logic [2:0] rel_q;
  logic [1:0] init_exp;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // cycles since reset release, saturating
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      rel_q <= 3'h0;
    else if (rel_q != 3'h7)
      rel_q <= rel_q + 3'h1;
  // power-on level picked by the straps
  assign init_exp[0] = (INIT_SEL[1:0] == 2'h1) | ((INIT_SEL[1:0] == 2'h2) & LAST_LVL[0]);
  assign init_exp[1] = (INIT_SEL[3:2] == 2'h1) | ((INIT_SEL[3:2] == 2'h2) & LAST_LVL[1]);
  property p_init_lvl; rel_q == 3'h4 |-> OUT_LINE == init_exp; endproperty
  property p_rd_ans; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  property p_rd_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  property p_rd_done; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY; endproperty
  property p_rd_stat;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `ADOP_OFF_STATUS |=> S_AXI_RDATA[1:0] == $past(OUT_LINE);
  endproperty
  property p_rd_err;
    S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h33 |=> S_AXI_RRESP == `ADOP_RESP_SLVERR && S_AXI_RDATA == 0;
  endproperty
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  property p_b_busy; S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY; endproperty
  property p_aw_drop; S_AXI_AWVALID && S_AXI_AWREADY |=> !S_AXI_AWREADY [*2]; endproperty
  a_init_lvl: assert property (p_init_lvl) else $error("initial line level wrong");
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  a_rd_done: assert property (p_rd_done) else $error("read not closed");
  a_rd_stat: assert property (p_rd_stat) else $error("status level wrong");
  a_rd_err: assert property (p_rd_err) else $error("unmapped read not refused");
  a_b_hold: assert property (p_b_hold) else $error("write response not held");
  a_b_busy: assert property (p_b_busy) else $error("ready during response");
  a_aw_drop: assert property (p_aw_drop) else $error("address ready not dropped");
  c_pulse: cover property ($rose(OUT_LINE[0]) ##[1:100] $fell(OUT_LINE[0]));
  c_werr: cover property (S_AXI_BVALID && S_AXI_BRESP == `ADOP_RESP_SLVERR);
  c_stat: cover property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == `ADOP_OFF_STATUS);
endmodule // adop_chk
bind adop_top adop_chk adop_chk_inst (.CLK(CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP),
  .INIT_SEL(INIT_SEL), .LAST_LVL(LAST_LVL), .OUT_LINE(OUT_LINE));
`default_nettype wire

// ---- adop_load.sv ----
// load model that times the level runs on output line zero
`timescale 1ns/10ps
`default_nettype none
module adop_load (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // driven line and measured runs
  input  wire logic        line,
  output var  logic [31:0] hi_len,
  output var  logic [31:0] lo_len,
  output var  logic [31:0] edges
);
  logic [31:0] run_q;
  logic        last_q;
  // close a run at each level change
  always_ff @(posedge clk or posedge rst)
    if (rst)
    begin
      run_q  <= 32'h0000_0000;
      last_q <= 1'b0;
      hi_len <= 32'h0000_0000;
      lo_len <= 32'h0000_0000;
      edges  <= 32'h0000_0000;
    end
    else if (line !== last_q)
    begin
      if (last_q)
        hi_len <= run_q;
      else
        lo_len <= run_q;
      run_q  <= 32'h0000_0001;
      edges  <= edges + 32'h0000_0001;
      last_q <= line;
    end
    else
      run_q <= run_q + 32'h0000_0001;
endmodule // adop_load
`default_nettype wire

// ---- tb_top.sv ----
// self-checking testbench for the alarm driven output pulser
`timescale 1ns/10ps
`default_nettype none
`include "adop_consts.vh"
module tb_top;
  localparam int MS = 10;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r; logic rd;} adop_exp_t;
  logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [1:0]  in_line;
  logic [3:0]  init_sel;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp, out_line;
  wire  [31:0] rdata, hi_len, lo_len, edges;
  adop_exp_t   exp_q[$];
  adop_exp_t   mon_e;
  int          bad_count, check_count, cyc;
  logic [14:0] lo, hi;
  logic [31:0] e0, e1;
  adop_top #(.MS_DIV(MS)) adop_top_inst (.CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .IN_LINE(in_line), .INIT_SEL(init_sel), .LAST_LVL(2'h2), .OUT_LINE(out_line));
  adop_load adop_load_inst (.clk(clk), .rst(rst), .line(out_line[0]), .hi_len(hi_len),
    .lo_len(lo_len), .edges(edges));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    check_count++;
    if (g !== x)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    exp_q.push_back('{32'h0000_0000, 32'h0000_0000, r, 1'b0});
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge clk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
    exp_q.push_back('{d, m, r, 1'b1});
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1)
      @(posedge clk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk);
    rready <= 1'b0;
  endtask
  task automatic set_in(input int i, input logic v);
    @(posedge clk);
    in_line[i] <= v;
  endtask
  task automatic wait_out(input int i, input logic v, input int n);
    int k;
    k = 0;
    while (out_line[i] !== v && k < n)
    begin
      @(posedge clk);
      k++;
    end
    chk("out_line", {31'h0000_0000, v}, {31'h0000_0000, out_line[i]});
  endtask
  // compare each bus answer against the oldest note
  always @(posedge clk)
    if ((rvalid === 1'b1 && rready) || (bvalid === 1'b1 && bready))
    begin
      mon_e = exp_q.pop_front();
      if (mon_e.rd)
        chk("rdata", mon_e.d & mon_e.m, rdata & mon_e.m);
      chk("resp", {30'h0000_0000, mon_e.r}, {30'h0000_0000, mon_e.rd ? rresp : bresp});
    end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      bad_count++;
      complete_run();
    end
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, in_line} = 50'h0;
    init_sel = 4'h9;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    void'($urandom(60));
    axi_rd(`ADOP_OFF_CTRL, {26'h000_0000, `ADOP_CTRL_RST}, 32'h0000_0001, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_CTRL, 32'h0000_0000, 32'h0000_0020, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_WIDTH + `ADOP_LINE_STRIDE, {17'h0_0000, `ADOP_WIDTH_RST}, 32'h0000_7FFF, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_WIDTH, {1'b0, `ADOP_WIDTH_RST, 16'h0000}, 32'h7FFF_0000, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_STATUS, 32'h0000_0003, 32'h0000_003F, `ADOP_RESP_OKAY);
    axi_rd(8'h40, 32'h0000_0000, ALL, `ADOP_RESP_SLVERR);
    axi_wr(8'h44, 32'h0000_FFFF, `ADOP_RESP_SLVERR);
    // disabled line stays put
    axi_wr(`ADOP_OFF_CTRL, 32'h0000_0008, `ADOP_RESP_OKAY);
    set_in(0, 1'b1);
    repeat (60) @(posedge clk);
    wait_out(0, 1'b1, 0);
    set_in(0, 1'b0);
    axi_wr(`ADOP_OFF_DELAY, 32'h0000_0003, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_DELAY, 32'h0000_0003, ALL, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_CTRL, 32'h0000_0009, `ADOP_RESP_OKAY);
    set_in(0, 1'b1);
    repeat (15) @(posedge clk);
    wait_out(0, 1'b1, 0);
    wait_out(0, 1'b0, 40);
    set_in(0, 1'b0);
    wait_out(0, 1'b1, 60);
    // square wave with random widths
    lo = 15'(1 + $urandom % 4);
    hi = 15'(1 + $urandom % 4);
    axi_wr(`ADOP_OFF_WIDTH, {1'b0, hi, 1'b0, lo}, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_CTRL, 32'h0000_0005, `ADOP_RESP_OKAY);
    set_in(0, 1'b1);
    repeat (3 * MS * (lo + hi) + 60) @(posedge clk);
    chk("high run", MS * hi, hi_len);
    chk("low run", MS * lo, lo_len);
    set_in(0, 1'b0);
    repeat (50) @(posedge clk);
    wait_out(0, 1'b0, 0);
    // second source and inversion on line one
    axi_wr(`ADOP_OFF_CTRL + `ADOP_LINE_STRIDE, 32'h0000_0029, `ADOP_RESP_OKAY);
    set_in(1, 1'b1);
    wait_out(1, 1'b0, 40);
    axi_wr(`ADOP_OFF_DICFG, 32'h0000_0002, `ADOP_RESP_OKAY);
    wait_out(1, 1'b1, 40);
    axi_rd(`ADOP_OFF_STATUS, 32'h0000_000A, 32'h0000_003F, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_CMD, 32'h0000_0008, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_STATUS, 32'h0000_0000, 32'h0000_0003, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_CMD, 32'h0000_0000, ALL, `ADOP_RESP_OKAY);
    // counter alarm on input one, then clear
    axi_wr(`ADOP_OFF_CTRL + `ADOP_LINE_STRIDE, 32'h0000_0000, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_DICFG, 32'h0000_0008, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_THR, 32'h0002_0000, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_CMD, 32'h0000_0002, `ADOP_RESP_OKAY);
    for (int k = 0; k < 4; k++)
    begin
      set_in(1, k[0]);
      repeat (5) @(posedge clk);
    end
    axi_rd(`ADOP_OFF_COUNT, 32'h0002_0000, 32'hFFFF_0000, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_STATUS, 32'h0000_0020, 32'h0000_0020, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_CMD, 32'h0000_0002, `ADOP_RESP_OKAY);
    axi_rd(`ADOP_OFF_STATUS, 32'h0000_0000, 32'h0000_0020, `ADOP_RESP_OKAY);
    // pulse action ended by a two second hold, first second may be short
    axi_wr(`ADOP_OFF_HOLD, 32'h0000_0002, `ADOP_RESP_OKAY);
    axi_wr(`ADOP_OFF_CTRL, 32'h0000_0015, `ADOP_RESP_OKAY);
    e0 = edges;
    set_in(0, 1'b1);
    repeat (21000) @(posedge clk);
    e1 = edges;
    chk("pulse ran", 32'h0000_0001, 32'(e1 > e0 + 2));
    repeat (1000) @(posedge clk);
    chk("edges after hold", e1, edges);
    // second reset, line zero strapped low by code three, line one to last level
    rst      <= 1'b1;
    init_sel <= 4'hB;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (6) @(posedge clk);
    axi_rd(`ADOP_OFF_STATUS, 32'h0000_0002, 32'h0000_0003, `ADOP_RESP_OKAY);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
